// ==== include/mcg_pkg.sv ====
// Constants for the global machine-check capability and status registers
package mcg_pkg;
    localparam int          ADDR_W            = 12;
    localparam int          DATA_W            = 64;
    // Register locations on the plain register port
    localparam logic [11:0] ADDR_CAPABILITY   = 12'h179;
    localparam logic [11:0] ADDR_GLOBAL_STAT  = 12'h17A;
    localparam logic [11:0] ADDR_GLOBAL_CTRL  = 12'h17B;
    localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h180;
    localparam logic [11:0] ADDR_IRQ_MASK     = 12'h181;
    // Capability fields
    localparam int          CAP_COUNT_LSB     = 0;
    localparam int          CAP_COUNT_W       = 8;
    localparam int          CAP_CTRL_BIT      = 8;
    // Global status fields
    localparam int          STAT_RESTART_BIT  = 0;
    localparam int          STAT_ERROR_BIT    = 1;
    localparam int          STAT_PROGRESS_BIT = 2;
    localparam int          STAT_W            = 3;
    localparam logic [2:0]  STAT_RESET        = 3'h0;
    // Interrupt event bits
    localparam int          IRQ_CHECK_BIT     = 0;
    localparam int          IRQ_SHUTDOWN_BIT  = 1;
    localparam int          IRQ_W             = 2;
    localparam logic [1:0]  IRQ_RESET         = 2'h0;
    localparam logic [63:0] CTRL_RESET        = 64'h0000000000000000;

    typedef enum logic [1:0] {
        MCG_RUN      = 2'h1,
        MCG_SHUTDOWN = 2'h2
    } mcg_state_t;
endpackage : mcg_pkg

// ==== src/mcg_global.sv ====
// Global machine-check capability, status, control and interrupt logic
// Behaviour
// RQ1: Capability low byte reports error bank count.
// RQ2: Capability bit 8 flags control register presence.
// RQ3: Check sets restart bit from restart qualifier.
// RQ4: Check sets error bit from association qualifier.
// RQ5: Check sets in-progress bit until software clears.
// RQ6: Check while in progress enters shutdown instead.
// RQ7: Software clears in-progress bit after handling.
// RQ8: Reserved bits read zero, writes ignored.
`timescale 1ns/1ps
`default_nettype none
module mcg_global #(
    parameter logic [7:0] BANK_COUNT   = 8'h05,
    parameter logic       CTRL_PRESENT = 1'h1
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic [11:0] i_addr,
    input  wire logic [63:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output var  logic [63:0] o_rdata,
    input  wire logic        i_check_event,
    input  wire logic        i_restart_ip_ok,
    input  wire logic        i_error_ip_assoc,
    output var  logic        o_check_raise,
    output var  logic        o_shutdown,
    output var  logic        o_irq
);

    // Check sequencing
    mcg_pkg::mcg_state_t state;
    mcg_pkg::mcg_state_t next_state;
    logic                next_check_raise;
    logic                next_shutdown;
    logic                check_ok;
    logic                check_fatal;

    // Global status and control
    logic [2:0]          status;
    logic [2:0]          next_status;
    logic [63:0]         ctrl;
    logic [63:0]         next_ctrl;

    // Interrupts
    logic [1:0]          irq_status;
    logic [1:0]          next_irq_status;
    logic [1:0]          irq_mask;
    logic [1:0]          next_irq_mask;
    logic                next_irq;

    // Register port
    logic [63:0]         next_rdata;

    // Decoded register strobes
    logic                wr_stat;
    logic                wr_ctrl;
    logic                wr_mask;
    logic                rd_cap;
    logic                rd_stat;
    logic                rd_ctrl;
    logic                rd_irq;
    logic                rd_mask;

    // Address compare, shared by every strobe decode
    function automatic logic hit(
        input logic [11:0] a,
        input logic [11:0] r
    );
        hit = (a == r);
    endfunction : hit

    // Capability word: fixed fields, reserved bits zero
    function automatic logic [63:0] cap_word(
        input logic [7:0] count,
        input logic       present
    );
        cap_word = 64'h0000000000000000;
        cap_word[mcg_pkg::CAP_COUNT_LSB +: mcg_pkg::CAP_COUNT_W] = count;
        cap_word[mcg_pkg::CAP_CTRL_BIT] = present;
    endfunction : cap_word

    // Zero-extends the status register into a read word
    function automatic logic [63:0] stat_word(input logic [2:0] v);
        stat_word = 64'h0000000000000000;
        stat_word[mcg_pkg::STAT_W-1:0] = v;
    endfunction : stat_word

    // Zero-extends an interrupt register into a read word
    function automatic logic [63:0] irq_word(input logic [1:0] v);
        irq_word = 64'h0000000000000000;
        irq_word[mcg_pkg::IRQ_W-1:0] = v;
    endfunction : irq_word

    // Status recorded by a check that is signalled normally
    function automatic logic [2:0] check_status(
        input logic restart,
        input logic assoc
    );
        check_status = mcg_pkg::STAT_RESET;
        check_status[mcg_pkg::STAT_RESTART_BIT]  = restart; // RQ3
        check_status[mcg_pkg::STAT_ERROR_BIT]    = assoc; // RQ4
        check_status[mcg_pkg::STAT_PROGRESS_BIT] = 1'h1; // RQ5
    endfunction : check_status

    // Level interrupt term: any sticky event that is not masked
    function automatic logic irq_level(
        input logic [1:0] events,
        input logic [1:0] mask
    );
        irq_level = |(events & mask);
    endfunction : irq_level

    // Write decode; writes to any other address are ignored
    always_comb begin
        wr_stat = i_wr && hit(i_addr, mcg_pkg::ADDR_GLOBAL_STAT);
        wr_ctrl = i_wr && CTRL_PRESENT &&
                  hit(i_addr, mcg_pkg::ADDR_GLOBAL_CTRL);
        wr_mask = i_wr && hit(i_addr, mcg_pkg::ADDR_IRQ_MASK);
    end

    // Read decode; reads of any other address return zero
    always_comb begin
        rd_cap  = i_rd && hit(i_addr, mcg_pkg::ADDR_CAPABILITY);
        rd_stat = i_rd && hit(i_addr, mcg_pkg::ADDR_GLOBAL_STAT);
        rd_ctrl = i_rd && CTRL_PRESENT &&
                  hit(i_addr, mcg_pkg::ADDR_GLOBAL_CTRL);
        rd_irq  = i_rd && hit(i_addr, mcg_pkg::ADDR_IRQ_STATUS);
        rd_mask = i_rd && hit(i_addr, mcg_pkg::ADDR_IRQ_MASK);
    end

    // Outcome of a check; judged on the registered in-progress bit
    always_comb begin
        check_ok    = 1'h0;
        check_fatal = 1'h0;
        // Events taken in shutdown change nothing
        if (i_check_event && (state == mcg_pkg::MCG_RUN)) begin
            check_fatal = status[mcg_pkg::STAT_PROGRESS_BIT]; // RQ6
            check_ok    = !status[mcg_pkg::STAT_PROGRESS_BIT]; // RQ5
        end
    end

    always_comb begin
        next_state       = state;
        next_check_raise = 1'h0;
        unique case (state)
            mcg_pkg::MCG_RUN: begin
                if (check_fatal) begin
                    next_state = mcg_pkg::MCG_SHUTDOWN; // RQ6
                end
                next_check_raise = check_ok;
            end
            mcg_pkg::MCG_SHUTDOWN: begin
                // Only reset leaves shutdown; further checks are dropped
                next_state = mcg_pkg::MCG_SHUTDOWN; // RQ6
            end
        endcase
        next_shutdown = (next_state == mcg_pkg::MCG_SHUTDOWN);
    end

    // Shutdown pin is its own flop so that no state decode reaches it
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state         <= mcg_pkg::MCG_RUN;
            o_check_raise <= 1'h0;
            o_shutdown    <= 1'h0;
        end else begin
            state         <= next_state;
            o_check_raise <= next_check_raise;
            o_shutdown    <= next_shutdown;
        end
    end

    // Global status; a normally signalled check overrides a same-cycle write
    always_comb begin
        next_status = status;
        if (wr_stat) begin
            // Upper write bits are dropped
            next_status[mcg_pkg::STAT_RESTART_BIT] =
                i_wdata[mcg_pkg::STAT_RESTART_BIT]; // RQ8
            next_status[mcg_pkg::STAT_ERROR_BIT] =
                i_wdata[mcg_pkg::STAT_ERROR_BIT];
            next_status[mcg_pkg::STAT_PROGRESS_BIT] =
                i_wdata[mcg_pkg::STAT_PROGRESS_BIT]; // RQ7
        end
        // A fatal check leaves the recorded status as it was
        if (check_ok) begin
            next_status = check_status(i_restart_ip_ok, i_error_ip_assoc);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status <= mcg_pkg::STAT_RESET;
        end else begin
            status <= next_status;
        end
    end

    // Global control storage, present only when the capability says so
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl = i_wdata;
        end
        if (!CTRL_PRESENT) begin
            // Absent register holds its reset value and reads zero
            next_ctrl = mcg_pkg::CTRL_RESET;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl <= mcg_pkg::CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Interrupt mask, same layout as the interrupt status
    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_mask) begin
            next_irq_mask = i_wdata[mcg_pkg::IRQ_W-1:0]; // RQ8
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_mask <= mcg_pkg::IRQ_RESET;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // Sticky events, cleared by a read; set after the clear so that an
    // event in the cycle of the clearing read is kept for the next read
    always_comb begin
        next_irq_status = irq_status;
        if (rd_irq) begin
            next_irq_status = mcg_pkg::IRQ_RESET;
        end
        if (check_ok) begin
            next_irq_status[mcg_pkg::IRQ_CHECK_BIT] = 1'h1;
        end
        if (check_fatal) begin
            next_irq_status[mcg_pkg::IRQ_SHUTDOWN_BIT] = 1'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_status <= mcg_pkg::IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Built from next values so the pin follows its registers in step
    always_comb begin
        next_irq = irq_level(next_irq_status, next_irq_mask);
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq <= 1'h0;
        end else begin
            o_irq <= next_irq;
        end
    end

    // Read data stand only in the cycle after the strobe, zero otherwise
    always_comb begin
        // Reserved upper bits of every word except the control word stay zero
        next_rdata = 64'h0000000000000000;
        if (rd_cap) begin
            next_rdata = cap_word(BANK_COUNT, CTRL_PRESENT); // RQ1 RQ2
        end
        if (rd_stat) begin
            next_rdata = stat_word(status); // RQ8
        end
        if (rd_ctrl) begin
            next_rdata = ctrl;
        end
        if (rd_irq) begin
            next_rdata = irq_word(irq_status);
        end
        if (rd_mask) begin
            next_rdata = irq_word(irq_mask); // RQ8
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 64'h0000000000000000;
        end else begin
            o_rdata <= next_rdata;
        end
    end
endmodule : mcg_global
`default_nettype wire

// ==== verification/mcg_global_sva.sv ====
// Port assertions for the global machine-check block
`timescale 1ns/1ps
`default_nettype none
module mcg_global_chk #(
    parameter logic [7:0] BANK_COUNT   = 8'h05,
    parameter logic       CTRL_PRESENT = 1'h1
) (
    input wire logic        i_core_clk,
    input wire logic        i_resetn,
    input wire logic [11:0] i_addr,
    input wire logic        i_rd,
    input wire logic [63:0] o_rdata,
    input wire logic        i_check_event,
    input wire logic        i_restart_ip_ok,
    input wire logic        i_error_ip_assoc,
    input wire logic        o_check_raise,
    input wire logic        o_shutdown
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_check;
        i_check_event && !o_shutdown ##1 o_check_raise;
    endsequence
    a_cap_fields: assert property (
        i_rd && i_addr == mcg_pkg::ADDR_CAPABILITY
        |=> o_rdata == {55'h0, CTRL_PRESENT, BANK_COUNT})
        else $error("capability read wrong");
    a_stat_fields: assert property (
        s_check ##0 (i_rd && i_addr == mcg_pkg::ADDR_GLOBAL_STAT)
        |=> o_rdata == {61'h0, 1'h1, $past(i_error_ip_assoc, 2),
                        $past(i_restart_ip_ok, 2)})
        else $error("status after check wrong");
    a_second_shut: assert property (
        o_check_raise && i_check_event |=> o_shutdown && !o_check_raise)
        else $error("second check did not shut down");
    a_shut_sticky: assert property (o_shutdown |=> o_shutdown)
        else $error("shutdown left");
    a_shut_quiet: assert property (o_shutdown |-> !o_check_raise)
        else $error("check raised in shutdown");
    a_unmapped_zero: assert property (
        i_rd && i_addr == 12'h100 |=> o_rdata == 64'h0)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 64'h0)
        else $error("read data outside read slot");
endmodule : mcg_global_chk
bind mcg_global mcg_global_chk #(.BANK_COUNT(BANK_COUNT),
    .CTRL_PRESENT(CTRL_PRESENT)) chk (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_check_event(i_check_event), .i_restart_ip_ok(i_restart_ip_ok),
    .i_error_ip_assoc(i_error_ip_assoc), .o_check_raise(o_check_raise),
    .o_shutdown(o_shutdown));
`default_nettype wire

// ==== verification/tb_top.sv ====
// Directed register bench for the global machine-check block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 0, rstn = 0, wr = 0, rd = 0, ev = 0, rs = 0, as = 0;
    logic [11:0] addr = 0;
    logic [63:0] wdata = 0, rdata;
    logic        raise, shut, irq;
    int          err_total = 0, check_count = 0;
    always #2.5 clk = ~clk;
    mcg_global #(.BANK_COUNT(8'h0C), .CTRL_PRESENT(1'h1)) uut (
        .i_core_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_check_event(ev),
        .i_restart_ip_ok(rs), .i_error_ip_assoc(as),
        .o_check_raise(raise), .o_shutdown(shut), .o_irq(irq));
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr_reg(input logic [11:0] a, input logic [63:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [11:0] a, input logic [63:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 cmp(rdata, e);
    endtask : rd_reg
    task automatic stop_test;
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        rd_reg(mcg_pkg::ADDR_CAPABILITY, {55'h0, 1'h1, 8'h0C});
        wr_reg(mcg_pkg::ADDR_CAPABILITY, '1);
        rd_reg(mcg_pkg::ADDR_CAPABILITY, {55'h0, 1'h1, 8'h0C});
        rd_reg(12'h100, 64'h0);
        wr_reg(mcg_pkg::ADDR_IRQ_MASK, 64'h3);
        @(posedge clk);
        ev <= 1;
        rs <= 1;
        @(posedge clk);
        ev <= 0;
        rd <= 1;
        addr <= mcg_pkg::ADDR_GLOBAL_STAT;
        #1 cmp(raise, 1);
        @(posedge clk);
        rd <= 0;
        #1 cmp(rdata, 64'h5);
        cmp(irq, 1);
        rd_reg(mcg_pkg::ADDR_IRQ_STATUS, 64'h1);
        wr_reg(mcg_pkg::ADDR_GLOBAL_STAT, '1);
        rd_reg(mcg_pkg::ADDR_GLOBAL_STAT, 64'h7);
        wr_reg(mcg_pkg::ADDR_GLOBAL_STAT, 64'h0);
        cmp(irq, 0);
        // Two checks back to back: the second finds bit 2 still set
        @(posedge clk);
        ev <= 1;
        rs <= 0;
        as <= 1;
        @(posedge clk);
        #1 cmp(raise, 1);
        @(posedge clk);
        ev <= 0;
        #1 cmp({shut, raise}, 2'h2);
        rd_reg(mcg_pkg::ADDR_GLOBAL_STAT, 64'h6);
        cmp(irq, 64'h1);
        rd_reg(mcg_pkg::ADDR_IRQ_STATUS, 64'h3);
        // Reset in mid-run leaves shutdown and clears the status
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        #1 cmp(shut, 64'h0);
        rd_reg(mcg_pkg::ADDR_GLOBAL_STAT, 64'h0);
        wr_reg(mcg_pkg::ADDR_GLOBAL_CTRL, 64'h0123456789ABCDEF);
        rd_reg(mcg_pkg::ADDR_GLOBAL_CTRL, 64'h0123456789ABCDEF);
        // A masked event must not reach the pin until unmasked
        @(posedge clk);
        ev <= 1'h1;
        rs <= 1'h1;
        as <= 1'h1;
        @(posedge clk);
        ev <= 1'h0;
        #1 cmp(raise, 64'h1);
        cmp(irq, 64'h0);
        wr_reg(mcg_pkg::ADDR_IRQ_MASK, 64'h1);
        cmp(irq, 64'h1);
        rd_reg(mcg_pkg::ADDR_GLOBAL_STAT, 64'h7);
        rd_reg(mcg_pkg::ADDR_IRQ_STATUS, 64'h1);
        cmp(irq, 64'h0);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
